// file: rtl/igp_ctrl.sv
// Host controller driving the six switch inputs and watching the fault line
module igp_ctrl
  import igp_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // Modulator requests, one high and one low per phase
  input wire logic [NUM_PHASE-1:0] HIGH_REQ,
  input wire logic [NUM_PHASE-1:0] LOW_REQ,
  // Software stop
  input wire logic STOP,
  // Device fault line, open drain
  input wire logic FAULT_OUT_N,
  // Per-phase overcurrent comparator results
  input wire logic [NUM_PHASE-1:0] OVERCURRENT_CMP,
  // Switch inputs to the device, active high
  output logic [NUM_PHASE-1:0] HIGH_IN,
  output logic [NUM_PHASE-1:0] LOW_IN,
  // Combined trip sense to the device
  output logic OVERCURRENT_SENSE_IN,
  // Fault status seen by the controller
  output logic FAULT_SEEN
);
  logic [2:0] fault_sync_r;
  logic fault_act_r;
  logic halt;
  logic [NUM_PHASE-1:0] high_on;
  logic [NUM_PHASE-1:0] low_on;
  // The cycle in which a pin rises adds one more, so both limits stop one short
  localparam logic [CNT_W-1:0] GAP_FULL = CNT_W'(GAP_CYC - 1);
  localparam logic [CNT_W-1:0] ON_FULL = CNT_W'(ON_CYC - 1);
  logic [NUM_PHASE-1:0] gap_ok;
  logic [NUM_PHASE-1:0] on_ok;
  logic [NUM_PHASE-1:0] run_mask;

  // ----------------------------------------
  // Fault line sampling
  // ----------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fault_sync_r <= 3'h7;
    end else begin
      fault_sync_r <= {fault_sync_r[1:0], FAULT_OUT_N};
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      fault_act_r <= 1'b0;
    end else if (fault_sync_r[2] == fault_sync_r[1]) begin
      fault_act_r <= !fault_sync_r[2];
    end
  end

  // Fault pulse means low sides are already forced off; stop driving too
  assign halt = fault_act_r || STOP;
  assign run_mask = {NUM_PHASE{!halt}};

  // ----------------------------------------
  // Phase legs
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PHASE; g++) begin : g_leg
      igp_leg u_leg (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .req_high(HIGH_REQ[g]),
        .req_low(LOW_REQ[g]),
        .halt(halt),
        .high_on_r(high_on[g]),
        .low_on_r(low_on[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Pin-level supervisor
  // ----------------------------------------
  // Second guard behind the legs: a leg fault cannot cut a gap, or an on pulse unless it raises the opposite side
  generate
    for (g = 0; g < NUM_PHASE; g++) begin : g_sup
      logic [CNT_W-1:0] idle_cnt_r;
      logic [CNT_W-1:0] on_cnt_r;
      logic leg_busy;

      assign leg_busy = high_on[g] || low_on[g] || HIGH_IN[g] || LOW_IN[g];

      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          idle_cnt_r <= GAP_FULL;
        end else if (leg_busy) begin
          idle_cnt_r <= CNT_ZERO;
        end else if (idle_cnt_r != GAP_FULL) begin
          idle_cnt_r <= idle_cnt_r + CNT_ONE;
        end
      end

      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          on_cnt_r <= CNT_ZERO;
        end else if (!(HIGH_IN[g] || LOW_IN[g])) begin
          on_cnt_r <= CNT_ZERO;
        end else if (on_cnt_r != ON_FULL) begin
          on_cnt_r <= on_cnt_r + CNT_ONE;
        end
      end

      assign gap_ok[g] = (idle_cnt_r == GAP_FULL);
      assign on_ok[g] = (on_cnt_r == ON_FULL);
    end
  endgenerate

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // high requests on
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HIGH_IN <= '0;
      LOW_IN <= '0;
    end else begin
      HIGH_IN <= (high_on & ~low_on & (HIGH_IN | gap_ok))
        | (HIGH_IN & ~low_on & ~on_ok & run_mask);
      LOW_IN <= (low_on & ~high_on & (LOW_IN | gap_ok))
        | (LOW_IN & ~high_on & ~on_ok & run_mask);
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OVERCURRENT_SENSE_IN <= 1'b0;
    end else begin
      OVERCURRENT_SENSE_IN <= |OVERCURRENT_CMP;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FAULT_SEEN <= 1'b0;
    end else begin
      FAULT_SEEN <= fault_act_r;
    end
  end
endmodule

// file: rtl/igp_pkg.sv
// Package: timing constants and types for the inverter gate-drive host controller
package igp_pkg;
  localparam int unsigned CLK_FREQ_MHZ = 200;
  // Leg blocking gap, least on pulse and least off pulse, in nanoseconds
  localparam int unsigned LEG_BLOCKING_GAP_NS = 2500;
  localparam int unsigned MIN_ON_PULSE_NS = 1000;
  localparam int unsigned MIN_OFF_PULSE_NS = 2000;
  // Least times round up to whole cycles
  localparam int unsigned GAP_CYC = (LEG_BLOCKING_GAP_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned ON_CYC = (MIN_ON_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned OFF_CYC = (MIN_OFF_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned NUM_PHASE = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  typedef enum logic [1:0] {
    IGP_OFF,
    IGP_HIGH_ON,
    IGP_LOW_ON
  } igp_leg_e;
endpackage

// file: rtl/igp_leg.sv
// One phase leg: gap-safe gating of the requested high and low switch states
module igp_leg
  import igp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request from the modulator, and halt on fault or software stop
  input wire logic req_high,
  input wire logic req_low,
  input wire logic halt,
  // Switch drives
  output logic high_on_r,
  output logic low_on_r
);
  igp_leg_e state_r;
  logic [CNT_W-1:0] cnt_r;
  logic cnt_done;

  assign cnt_done = (cnt_r == CNT_ZERO);

  // ----------------------------------------
  // Leg sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IGP_OFF;
      cnt_r <= CNT_ZERO;
    end else begin
      unique case (state_r)
        IGP_OFF: begin
          if (!cnt_done) begin
            cnt_r <= cnt_r - CNT_ONE;
          end else if (!halt && req_high && !req_low) begin
            state_r <= IGP_HIGH_ON;
            cnt_r <= CNT_W'(ON_CYC - 1);
          end else if (!halt && req_low && !req_high) begin
            state_r <= IGP_LOW_ON;
            cnt_r <= CNT_W'(ON_CYC - 1);
          end
        end
        IGP_HIGH_ON, IGP_LOW_ON: begin
          if (!cnt_done) begin
            cnt_r <= cnt_r - CNT_ONE;
          end
          // Halt overrides the on hold: protection first
          if (halt || (cnt_done && !((state_r == IGP_HIGH_ON) ? req_high : req_low))) begin
            state_r <= IGP_OFF;
            cnt_r <= CNT_W'(((GAP_CYC > OFF_CYC) ? GAP_CYC : OFF_CYC) - 1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_on_r <= 1'b0;
      low_on_r <= 1'b0;
    end else begin
      high_on_r <= (state_r == IGP_HIGH_ON) && !halt;
      low_on_r <= (state_r == IGP_LOW_ON) && !halt;
    end
  end
endmodule

// file: tb/igp_dev.sv
// Behavioural power stage seen by the controller
module igp_dev #(parameter int W = 40) (
  input wire logic clk, input wire logic rst_n, input wire logic sc, input wire logic vd_ok,
  input wire logic [2:0] vdb_ok, input wire logic [2:0] hi, input wire logic [2:0] lo,
  output logic [2:0] hg, output logic [2:0] lg, output logic fo_oe);
  logic [2:0] hp, lp, ha, la;
  int n;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) n <= 0;
    else if ((sc && n == 0) || !vd_ok) n <= W;
    else if (n != 0) n <= n - 1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) begin
      {hp, lp, ha, la} <= 12'h000;
    end else begin
      hp <= hi;
      lp <= lo;
      ha <= vdb_ok & (ha | (hi & ~hp));
      la <= (sc || n != 0 || !vd_ok) ? 3'h0 : (la | (lo & ~lp));
    end
  // active high gates, open drain fault
  assign hg = hi & ha;
  assign lg = lo & la;
  assign fo_oe = n != 0;
endmodule

// file: tb/igp_ctrl_props.sv
// Port checker for the controller
module igp_chk import igp_pkg::*; (input wire logic REF_CLK, input wire logic RESETN,
  input wire logic [2:0] HIGH_REQ, input wire logic [2:0] LOW_REQ,
  input wire logic FAULT_OUT_N, input wire logic [2:0] OVERCURRENT_CMP,
  input wire logic [2:0] HIGH_IN, input wire logic [2:0] LOW_IN,
  input wire logic OVERCURRENT_SENSE_IN, input wire logic FAULT_SEEN);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  int on_c, off_c;
  // Gap count starts full: nothing owed after reset
  always_ff @(posedge REF_CLK or negedge RESETN)
    if (!RESETN) begin
      on_c <= 0;
      off_c <= GAP_CYC;
    end else begin
      on_c <= HIGH_IN[0] ? on_c + 1 : 0;
      off_c <= (HIGH_IN[0] | LOW_IN[0]) ? 0 : off_c + 1;
    end
  a_no_leg_overlap: assert property ((HIGH_IN & LOW_IN) == 3'h0) else $error("overlap");
  a_leg_off_gap: assert property ($rose(HIGH_IN[0] | LOW_IN[0]) |-> off_c >= GAP_CYC)
    else $error("gap");
  a_min_on_time: assert property ($fell(HIGH_IN[0]) |-> on_c >= ON_CYC) else $error("on");
  a_high_req_lat: assert property ($rose(HIGH_IN[0]) |-> $past(HIGH_REQ[0], 3))
    else $error("high");
  a_low_req_lat: assert property ($rose(LOW_IN[0]) |-> $past(LOW_REQ[0], 3))
    else $error("low");
  a_sense_or_join: assert property (OVERCURRENT_SENSE_IN == |$past(OVERCURRENT_CMP))
    else $error("or");
  a_fault_halts_all: assert property ($fell(FAULT_OUT_N) ##1 !FAULT_OUT_N[*6]
    |=> (HIGH_IN | LOW_IN) == 3'h0) else $error("halt");
  a_fault_seen_set: assert property (!FAULT_OUT_N[*7] |-> FAULT_SEEN) else $error("seen");
  c_trip: cover property ($fell(FAULT_OUT_N));
  c_high_on: cover property ($rose(HIGH_IN[0]));
  c_low_on: cover property ($rose(LOW_IN[0]));
endmodule
bind igp_ctrl igp_chk chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .HIGH_REQ(HIGH_REQ),
  .LOW_REQ(LOW_REQ), .FAULT_OUT_N(FAULT_OUT_N), .OVERCURRENT_CMP(OVERCURRENT_CMP),
  .HIGH_IN(HIGH_IN), .LOW_IN(LOW_IN), .OVERCURRENT_SENSE_IN(OVERCURRENT_SENSE_IN),
  .FAULT_SEEN(FAULT_SEEN));

// file: tb/testbench.sv
// Bench: controller driving a behavioural power stage
module testbench import igp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, vd = 1, stop = 0, sens, seen, fo_oe;
  logic [2:0] hq = 3'h0, lq = 3'h0, cmp = 3'h0, high_side_boot_supply = 3'h7, hi, li, hg, lg;
  wire fo_n = fo_oe ? 1'b0 : 1'b1;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #2.5 clk = ~clk;
  igp_ctrl uut (.REF_CLK(clk), .RESETN(rst_n), .HIGH_REQ(hq), .LOW_REQ(lq), .STOP(stop),
    .FAULT_OUT_N(fo_n), .OVERCURRENT_CMP(cmp), .HIGH_IN(hi), .LOW_IN(li),
    .OVERCURRENT_SENSE_IN(sens), .FAULT_SEEN(seen));
  igp_dev #(.W(40)) dev (.clk(clk), .rst_n(rst_n), .sc(sens), .vd_ok(vd), .vdb_ok(high_side_boot_supply),
    .hi(hi), .lo(li), .hg(hg), .lg(lg), .fo_oe(fo_oe));
  task automatic cy(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(string nm, logic [2:0] e, logic [2:0] s);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Whole run is near 3k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic t_leg;
    hq[0] = 1;
    cy(4);
    chk("gate hi", 3'h1, hg);
    cy(ON_CYC);
    hq[0] = 0;
    lq[0] = 1;
    cy(GAP_CYC - 60);
    chk("gap lo", 3'h0, li);
    cy(80);
    chk("lo on", 3'h1, lg);
  endtask
  task automatic t_trip;
    cmp[2] = 1;
    cy(1);
    cmp[2] = 0;
    cy(3);
    chk("trip gate", 3'h0, lg);
    cy(6);
    chk("seen", 3'h1, {2'h0, seen});
    cy(50);
    chk("pulse end", 3'h0, {2'h0, seen});
    cy(GAP_CYC + 60);
    chk("rearm", 3'h1, lg);
  endtask
  task automatic t_uv;
    vd = 0;
    cy(3);
    chk("uv gate", 3'h0, lg);
    cy(100);
    chk("uv held", 3'h1, {2'h0, seen});
    vd = 1;
    cy(GAP_CYC + 100);
    chk("uv rearm", 3'h1, lg);
  endtask
  task automatic t_boot;
    hq[1] = 1;
    cy(ON_CYC);
    high_side_boot_supply[1] = 0;
    cy(10);
    chk("boot off", 3'h1, hg | lg);
    chk("boot quiet", 3'h0, {2'h0, seen});
    high_side_boot_supply[1] = 1;
    cy(2);
    chk("boot hold", 3'h0, hg);
  endtask
  task automatic t_stop;
    stop = 1;
    cy(3);
    chk("stop off", 3'h0, hi | li);
    stop = 0;
    cy(GAP_CYC - 20);
    chk("stop gap", 3'h0, hi | li);
    cy(40);
    chk("stop hi", 3'h2, hi);
    chk("stop lo", 3'h1, li);
  endtask
  initial begin
    cy(6);
    rst_n = 1;
    cy(2);
    chk("reset", 3'h0, hi | li);
    t_leg();
    t_trip();
    t_uv();
    t_boot();
    t_stop();
    end_sim();
  end
endmodule
